// ---- verilog/cid_ident_regs.sv ----
// CAN message buffer identifier registers: tx buffers, one rx buffer.
// Assumes an APB master on pclk and a CAN engine that drives the link
// strobes synchronously to pclk.
// Identifier bytes have no reset; flags, selection, APB read data/error and the shifter do.
//
// How it works
// - CPU writes to rx ident are ignored
// - ident storage is uninitialised RAM-like storage
// - extended layout: 29 ID bits, SRR, IDE, RTR
// - standard layout: 11 ID bits, RTR, IDE
// - standard field positions in bytes 0 and 1
// - extended field positions across bytes 0 to 3
// - top identifier bit is sent first
// - smaller identifier value wins arbitration
// - received SRR stored as sampled
// - IDE selects format; transmitter follows IDE
// - received IDE marks received frame format
// - RTR 0 data, 1 remote; stored on receive
// - transmitted RTR equals the programmed RTR
//
// Added by the designer: the APB slave port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module cid_ident_regs
   import cid_pkg::*;
#(
   parameter int NUM_TX = 3                    // Number of transmit buffers
) (
   input  wire logic                    pclk,
   input  wire logic                    presetn,
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [7:0]              paddr,
   input  wire logic [31:0]             pwdata,
   input  wire logic [3:0]              pstrb,
   output logic                         pready,
   output logic [31:0]                  prdata,
   output logic                         pslverr,
   input  wire logic                    rx_store,
   input  wire logic [28:0]             rx_id,
   input  wire logic                    rx_ide,
   input  wire logic                    rx_rtr,
   input  wire logic                    rx_srr,
   output logic                         rx_ready,
   output logic                         tx_pending,
   output logic [28:0]                  tx_key,
   input  wire logic [28:0]             bus_key,
   output logic                         tx_outranks,
   input  wire logic                    tx_start,
   input  wire logic                    tx_shift,
   output logic                         tx_bit,
   output logic                         tx_bit_valid,
   input  wire logic                    tx_done
);

   // Pack a received frame into the four identifier bytes {b0,b1,b2,b3}
   function automatic logic [31:0] pack_ident(input logic [28:0] id, input logic ide,
                                              input logic rtr, input logic srr);
      logic [31:0] w;
      // Unused bits are zero rather than stale storage
      w = 32'h0000_0000;
      if (ide) begin
         // Extended layout
         w[31:24] = id[28:21];
         w[23:21] = id[20:18];
         w[16+CID_B1_SRR_POS] = srr;              // Kept as sampled
         w[16+CID_B1_IDE_POS] = 1'b1;
         w[18:16] = id[17:15];
         w[15:8]  = id[14:7];
         w[7:1]   = id[6:0];
         w[CID_B3_EXT_RTR_POS] = rtr;
      end else begin
         // Standard layout; unused bits carry no meaning
         w[31:24] = id[10:3];
         w[23:21] = id[2:0];
         w[16+CID_B1_STD_RTR_POS] = rtr;
         w[16+CID_B1_IDE_POS] = 1'b0;
      end
      return w;
   endfunction

   // Identifier of a packed word, left aligned to 29 bits for comparison
   function automatic logic [28:0] ident_key(input logic [31:0] w);
      logic [28:0] k;
      // Standard ids sit in the top 11 bits, so both formats compare
      if (w[16+CID_B1_IDE_POS]) begin
         k = {w[31:21], w[18:16], w[15:8], w[7:1]};
      end else begin
         k = {w[31:21], 18'h00000};
      end
      return k;
   endfunction

   // Bits in bus order, MSB first, left aligned in the vector
   function automatic logic [31:0] arb_seq(input logic [31:0] w);
      logic [31:0] s;
      if (w[16+CID_B1_IDE_POS]) begin
         // ID28..18, SRR, IDE, ID17..0, RTR
         s = {w[31:21], w[16+CID_B1_SRR_POS], 1'b1, w[18:16], w[15:8], w[7:1],
              w[CID_B3_EXT_RTR_POS]};
      end else begin
         // ID10..0, RTR, IDE
         // The zero tail below the 13 bits is never shifted out
         s = {w[31:21], w[16+CID_B1_STD_RTR_POS], 1'b0, 19'h00000};
      end
      return s;
   endfunction

   // Lowest set bit of a buffer mask, as an index
   function automatic logic [$clog2(NUM_TX+1)-1:0] low_index(input logic [NUM_TX-1:0] m);
      logic [$clog2(NUM_TX+1)-1:0] r;
      r = '0;
      // Scan from the top so the lowest set bit is the last to land
      for (int i = NUM_TX - 1; i >= 0; i--) begin
         if (m[i]) begin
            r = i[$clog2(NUM_TX+1)-1:0];
         end
      end
      return r;
   endfunction

   // One spare code keeps the width legal for a single buffer
   localparam int IW = $clog2(NUM_TX + 1);     // Buffer index width

   // Identifier storage, no reset on purpose
   logic [31:0]          tx_ram [NUM_TX];      // Transmit buffers
   logic [31:0]          rx_ram;               // Receive buffer

   // Control state
   // Flags, selection, APB read data/error and shifter are the only state that reset touches
   logic [NUM_TX-1:0]    tx_empty_q;           // tx_buffer_empty_flag per buffer
   logic [NUM_TX-1:0]    tx_empty_d;
   logic [NUM_TX-1:0]    tx_sel_q;             // tx_buffer_selection
   logic                 rx_full_q;            // rx_buffer_full_flag
   logic                 rx_full_d;
   logic [31:0]          prdata_q;             // Read data captured in setup
   logic                 pslverr_q;            // Error captured in setup
   cid_tx_state_e        tx_state_q;           // Shifter state
   cid_tx_state_e        tx_state_d;
   logic [31:0]          shift_q;              // Arbitration bit stream
   logic [5:0]           left_q;               // Bits still to send
   logic [IW-1:0]        send_idx_q;           // Buffer being sent

   // Bus decode
   // Idents decode on the upper nibble, byte number on bits 3:2
   wire                  setup_ph  = psel & ~penable;
   wire                  wr_acc    = psel & penable & pwrite;
   wire                  hit_tx    = (paddr[7:4] == CID_TX_IDENT0_OFS[7:4]);
   wire                  hit_rx    = (paddr[7:4] == CID_RX_IDENT0_OFS[7:4]);
   wire                  hit_sel   = (paddr == CID_TX_SEL_OFS);
   wire                  hit_tflag = (paddr == CID_TX_FLAG_OFS);
   wire                  hit_rflag = (paddr == CID_RX_FLAG_OFS);
   wire                  aligned   = (paddr[1:0] == 2'b00);
   wire                  mapped    = aligned & (hit_tx | hit_rx | hit_sel | hit_tflag | hit_rflag);
   wire [1:0]            byte_no   = paddr[3:2];

   // Selected tx buffer: lowest selected bit
   // Extra selection bits are ignored: one window at a time
   wire [IW-1:0]         sel_idx   = low_index(tx_sel_q);
   wire                  sel_any   = |tx_sel_q;
   wire                  sel_empty = tx_empty_q[sel_idx[IW-1:0] % NUM_TX];

   // CPU window onto tx buffer needs empty flag and selection
   wire                  tx_open   = sel_any & sel_empty;
   // CPU window onto rx buffer needs full flag
   wire                  rx_open   = rx_full_q;

   // Buffer chosen for sending: lowest index that is queued
   wire [NUM_TX-1:0]     queued    = ~tx_empty_q;
   wire [IW-1:0]         pick_idx  = low_index(queued);
   wire [31:0]           pick_word = tx_ram[pick_idx % NUM_TX];

   // Strobes from software
   // A frame offered while full is dropped; the engine must retry
   wire                  wr_tx     = wr_acc & hit_tx & aligned & tx_open & pstrb[0];
   wire                  wr_sel    = wr_acc & hit_sel & pstrb[0];
   wire                  wr_tflag  = wr_acc & hit_tflag & pstrb[0];
   wire                  wr_rflag  = wr_acc & hit_rflag & pstrb[0];
   wire                  rx_take   = rx_store & ~rx_full_q;

   // Read mux for the addressed register
   logic [31:0]          rd_word;
   logic [7:0]           rd_byte;

   // Pick byte of a packed identifier word
   // Closed windows read zero, so stale frames never leak
   always_comb begin
      rd_byte = 8'h00;
      rd_word = 32'h0000_0000;
      if (hit_tx && tx_open) begin
         rd_byte = tx_ram[sel_idx % NUM_TX][8*(3-byte_no) +: 8];
      end else if (hit_rx && rx_open) begin
         rd_byte = rx_ram[8*(3-byte_no) +: 8];
      end
      if (hit_tx || hit_rx) begin
         rd_word = {24'h000000, rd_byte};
      end else if (hit_sel) begin
         rd_word[NUM_TX-1:0] = tx_sel_q;
      end else if (hit_tflag) begin
         rd_word[NUM_TX-1:0] = tx_empty_q;
      end else if (hit_rflag) begin
         rd_word[CID_RX_FULL_POS] = rx_full_q;
      end
   end

   // Tx storage writes; the CPU byte lands in the ident byte picked by byte_no
   // Only lane 0 carries data: one byte per register word
   // Software is trusted to write SRR as 1
   always_ff @(posedge pclk) begin
      if (wr_tx) begin
         tx_ram[sel_idx % NUM_TX][8*(3-byte_no) +: 8] <= pwdata[7:0];
      end
   end

   // Rx storage has only the engine as writer
   // Stored whole in one cycle, so software never sees half a frame
   always_ff @(posedge pclk) begin
      if (rx_take) begin
         rx_ram <= pack_ident(rx_id, rx_ide, rx_rtr, rx_srr);
      end
   end

   // Empty flags: write 1 queues a buffer, tx_done frees it; set wins
   // A tx_done only counts while a frame is in flight
   always_comb begin
      tx_empty_d = tx_empty_q;
      if (wr_tflag) begin
         tx_empty_d = tx_empty_q & ~pwdata[NUM_TX-1:0];
      end
      if (tx_done && tx_state_q != CID_TX_IDLE) begin
         tx_empty_d[send_idx_q % NUM_TX] = 1'b1;
      end
   end

   // Full flag: write 1 releases, a stored frame sets; set wins
   // Release and new frame together leave the buffer empty; the offered frame is dropped
   always_comb begin
      rx_full_d = rx_full_q;
      if (wr_rflag && pwdata[CID_RX_FULL_POS]) begin
         rx_full_d = 1'b0;
      end
      if (rx_take) begin
         rx_full_d = 1'b1;
      end
   end

   // Flag and selection registers
   // Changing selection does not touch frames already queued
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_empty_q <= {NUM_TX{CID_TX_EMPTY_RST}};
         tx_sel_q   <= '0;
         rx_full_q  <= CID_RX_FULL_RST;
      end else begin
         tx_empty_q <= tx_empty_d;
         rx_full_q  <= rx_full_d;
         if (wr_sel) begin
            tx_sel_q <= pwdata[NUM_TX-1:0];
         end
      end
   end

   // Read data and error are latched in setup, so they come from flops
   // Trade-off: no glitches on prdata, but it reflects the setup cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q  <= 32'h0000_0000;
         pslverr_q <= 1'b0;
      end else if (setup_ph) begin
         prdata_q  <= rd_word;
         pslverr_q <= ~mapped;
      end
   end

   // Shifter next state
   // WAIT holds the shifter until the engine ends the frame; tx_bit is recessive there only after an extended frame
   always_comb begin
      tx_state_d = tx_state_q;
      case (tx_state_q)
         CID_TX_IDLE: begin
            if (tx_start && tx_pending) begin
               tx_state_d = CID_TX_SHIFT;
            end
         end
         CID_TX_SHIFT: begin
            if (tx_done) begin
               tx_state_d = CID_TX_IDLE;
            end else if (tx_shift && left_q == 6'd1) begin
               tx_state_d = CID_TX_WAIT;
            end
         end
         CID_TX_WAIT: begin
            if (tx_done) begin
               tx_state_d = CID_TX_IDLE;
            end
         end
         default: begin
            tx_state_d = CID_TX_IDLE;
         end
      endcase
   end

   // Arbitration shifter; MSB first, idle bit is recessive
   // A cut frame (tx_done while shifting) stops the shift at once
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_state_q <= CID_TX_IDLE;
         shift_q    <= {CID_SEQ_W{CID_ARB_IDLE_BIT}};
         left_q     <= 6'd0;
         send_idx_q <= '0;
      end else begin
         tx_state_q <= tx_state_d;
         if (tx_state_q == CID_TX_IDLE && tx_start && tx_pending) begin
            // Format and RTR follow the stored buffer
            shift_q    <= arb_seq(pick_word);
            left_q     <= pick_word[16+CID_B1_IDE_POS] ? CID_EXT_SEQ_LEN : CID_STD_SEQ_LEN;
            send_idx_q <= pick_idx;
         end else if (tx_state_q == CID_TX_SHIFT && tx_shift && !tx_done) begin
            shift_q <= {shift_q[30:0], CID_ARB_IDLE_BIT};
            left_q  <= left_q - 6'd1;
         end
      end
   end

   // Outputs
   // No wait states, so pready needs no register
   assign pready       = 1'b1;                     // Zero wait states
   assign prdata       = prdata_q;
   assign pslverr      = pslverr_q & psel & penable;
   assign rx_ready     = ~rx_full_q;               // Engine holds frames while full
   assign tx_pending   = |queued;
   // Undefined until the chosen buffer's identifier is written
   assign tx_key       = ident_key(pick_word);
   // Smaller identifier wins; ties do not outrank
   assign tx_outranks  = tx_pending & (tx_key < bus_key);
   assign tx_bit       = shift_q[31];
   assign tx_bit_valid = (tx_state_q == CID_TX_SHIFT);

endmodule
`default_nettype wire

// ---- verilog/cid_pkg.sv ----
// Package for the CAN message buffer identifier block.
// Assumes a 32-bit APB register bus and one byte per register word.
package cid_pkg;

   // Register byte addresses
   localparam logic [7:0] CID_TX_IDENT0_OFS = 8'h00; // ident_byte_0, selected tx buffer
   localparam logic [7:0] CID_TX_IDENT1_OFS = 8'h04; // ident_byte_1, selected tx buffer
   localparam logic [7:0] CID_TX_IDENT2_OFS = 8'h08; // ident_byte_2, selected tx buffer
   localparam logic [7:0] CID_TX_IDENT3_OFS = 8'h0c; // ident_byte_3, selected tx buffer
   localparam logic [7:0] CID_RX_IDENT0_OFS = 8'h10; // ident_byte_0, receive buffer
   localparam logic [7:0] CID_RX_IDENT3_OFS = 8'h1c; // ident_byte_3, receive buffer
   localparam logic [7:0] CID_TX_SEL_OFS    = 8'h20; // tx_buffer_selection
   localparam logic [7:0] CID_TX_FLAG_OFS   = 8'h24; // tx_flag_register
   localparam logic [7:0] CID_RX_FLAG_OFS   = 8'h28; // rx_flag_register

   // Field positions inside the identifier bytes
   localparam int CID_B1_SRR_POS     = 4;  // Extended layout, byte 1
   localparam int CID_B1_IDE_POS     = 3;  // Both layouts, byte 1
   localparam int CID_B1_STD_RTR_POS = 4;  // Standard layout, byte 1
   localparam int CID_B3_EXT_RTR_POS = 0;  // Extended layout, byte 3
   localparam int CID_RX_FULL_POS    = 0;  // Receive flag register

   // Identifier widths and arbitration field lengths
   localparam int CID_EXT_ID_W  = 29;
   localparam int CID_STD_ID_W  = 11;
   localparam int CID_SEQ_W     = 32;      // Extended: ID, SRR, IDE, RTR
   localparam logic [5:0] CID_EXT_SEQ_LEN = 6'd32;
   localparam logic [5:0] CID_STD_SEQ_LEN = 6'd13; // ID, RTR, IDE

   // Reset values of control state
   localparam logic CID_TX_EMPTY_RST = 1'b1;  // All tx buffers free
   localparam logic CID_RX_FULL_RST  = 1'b0;  // Receive buffer free
   localparam logic CID_ARB_IDLE_BIT = 1'b1;  // Recessive level

   // Transmit shifter states
   typedef enum logic [1:0] {CID_TX_IDLE, CID_TX_SHIFT, CID_TX_WAIT} cid_tx_state_e;

endpackage

// ---- sim/cid_ident_checker.sv ----
// Assertions on the identifier register block's ports.
// Assumes it is bound into cid_ident_regs: one clock, async low reset.
`timescale 1ns/1ns
`default_nettype none
module cid_ident_checker
   import cid_pkg::*;
#(
   parameter int NUM_TX = 3                    // Transmit buffer count
) (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   input  wire logic        pslverr,
   input  wire logic        rx_store,
   input  wire logic        rx_ready,
   input  wire logic        tx_pending,
   input  wire logic [28:0] tx_key,
   input  wire logic [28:0] bus_key,
   input  wire logic        tx_outranks,
   input  wire logic        tx_start,
   input  wire logic        tx_shift,
   input  wire logic        tx_bit,
   input  wire logic        tx_bit_valid,
   input  wire logic        tx_done
);
   default clocking dcb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // Access phase of a write that frees the receive buffer
   wire logic       rx_clr  = psel && penable && pwrite && paddr == CID_RX_FLAG_OFS && pwdata[0];
   wire logic       key_top = tx_key[28];      // Bit that must go out first
   logic      [5:0] shifts_q;                  // Shifts seen in this frame
   // Shift counter, cleared per frame so a stale count cannot pass
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn)
         shifts_q <= 6'h00;
      else if (tx_start)
         shifts_q <= 6'h00;
      else if (tx_shift && tx_bit_valid)
         shifts_q <= shifts_q + 6'h01;
   end
   AST_RX_WR_OK: assert property (
      psel && penable && pwrite && paddr[7:4] == 4'h1 |-> !pslverr) else $error("rx write err");
   AST_RX_TAKE: assert property (
      rx_store && rx_ready |=> !rx_ready) else $error("rx frame not taken");
   AST_RX_IDLE: assert property (
      rx_ready && !rx_store |=> rx_ready) else $error("rx full from nothing");
   AST_RX_HOLD: assert property (
      !rx_ready && !rx_clr |=> !rx_ready) else $error("rx full lost");
   AST_RANK: assert property (
      tx_pending |-> tx_outranks == (tx_key < bus_key)) else $error("bad rank");
   AST_RANK_IDLE: assert property (
      !tx_pending |-> !tx_outranks) else $error("rank with no frame");
   AST_FIRST: assert property (
      tx_start && tx_pending && !tx_bit_valid |=> tx_bit_valid && tx_bit == $past(key_top))
      else $error("bad first bit");
   AST_BIT_HOLD: assert property (
      tx_bit_valid && !tx_shift && !tx_done |=> $stable(tx_bit)) else $error("bit moved");
   AST_LEN: assert property (
      $fell(tx_bit_valid) && !$past(tx_done) |-> shifts_q == 6'h20 || shifts_q == 6'h0d)
      else $error("bad frame length");
   AST_DONE: assert property (
      tx_done |=> !tx_bit_valid) else $error("still sending");
endmodule
bind cid_ident_regs cid_ident_checker #(.NUM_TX(NUM_TX)) cid_ident_checker_inst (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .rx_store(rx_store),
   .rx_ready(rx_ready), .tx_pending(tx_pending), .tx_key(tx_key), .bus_key(bus_key),
   .tx_outranks(tx_outranks), .tx_start(tx_start), .tx_shift(tx_shift), .tx_bit(tx_bit),
   .tx_bit_valid(tx_bit_valid), .tx_done(tx_done));
`default_nettype wire

// ---- sim/cid_can_node.sv ----
// Behavioural CAN engine/bus node facing the identifier block.
// Assumes the bench calls its tasks; all drives follow a pclk edge.
`timescale 1ns/1ns
`default_nettype none
module cid_can_node (
   input  wire logic        pclk,
   input  wire logic        tx_bit,
   output logic             rx_store,
   output logic [28:0]      rx_id,
   output logic             rx_ide,
   output logic             rx_rtr,
   output logic             rx_srr,
   output logic             tx_start,
   output logic             tx_shift,
   output logic             tx_done
);
   // Quiet link at time zero
   initial begin
      {rx_store, rx_id, rx_ide, rx_rtr, rx_srr} = '0;
      {tx_start, tx_shift, tx_done} = '0;
   end
   // One received frame; stale fields are inverted so none is reused
   task automatic offer(input logic [28:0] id, input logic ide, input logic rtr, input logic srr);
      @(posedge pclk);
      rx_store <= 1'h1;
      {rx_id, rx_ide, rx_rtr, rx_srr} <= {id, ide, rtr, srr};
      @(posedge pclk);
      rx_store <= 1'h0;
      {rx_id, rx_ide, rx_rtr, rx_srr} <= ~{id, ide, rtr, srr};
   endtask
   // Start a frame and shift out n bits, slow adds a stall per bit
   task automatic send(input int n, input bit slow, output logic [31:0] bits);
      bits = 32'h0;
      @(posedge pclk);
      tx_start <= 1'h1;
      @(posedge pclk);
      tx_start <= 1'h0;
      for (int i = 0; i < n; i++) begin
         if (slow)
            @(posedge pclk);
         @(posedge pclk);
         bits = {bits[30:0], tx_bit};
         tx_shift <= 1'h1;
         @(posedge pclk);
         tx_shift <= 1'h0;
      end
   endtask
   // End of frame strobe
   task automatic end_frame();
      @(posedge pclk);
      tx_done <= 1'h1;
      @(posedge pclk);
      tx_done <= 1'h0;
   endtask
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// Self-checking bench for the identifier register block.
// Assumes zero wait APB slave and the byte offsets of cid_pkg.
`timescale 1ns/1ns
`default_nettype none
module tb
   import cid_pkg::*;
;
   localparam logic [28:0] ID = 29'h12345679; // Extended test identifier
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
   logic [7:0]  paddr;
   logic [3:0]  pstrb;
   logic [31:0] pwdata, prdata, rd, w, m, bits;
   logic        rx_store, rx_ide, rx_rtr, rx_srr, rx_ready, tx_pending, tx_outranks;
   logic        tx_start, tx_shift, tx_bit, tx_bit_valid, tx_done;
   logic [28:0] rx_id, tx_key, bus_key, key;
   int          failures, checked;
   cid_ident_regs #(.NUM_TX(3)) cid_ident_regs_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
      .pslverr(pslverr), .rx_store(rx_store), .rx_id(rx_id), .rx_ide(rx_ide),
      .rx_rtr(rx_rtr), .rx_srr(rx_srr), .rx_ready(rx_ready), .tx_pending(tx_pending),
      .tx_key(tx_key), .bus_key(bus_key), .tx_outranks(tx_outranks), .tx_start(tx_start),
      .tx_shift(tx_shift), .tx_bit(tx_bit), .tx_bit_valid(tx_bit_valid), .tx_done(tx_done));
   cid_can_node cid_can_node_inst (
      .pclk(pclk), .tx_bit(tx_bit), .rx_store(rx_store), .rx_id(rx_id), .rx_ide(rx_ide),
      .rx_rtr(rx_rtr), .rx_srr(rx_srr), .tx_start(tx_start), .tx_shift(tx_shift),
      .tx_done(tx_done));
   // 20 MHz clock
   initial begin
      pclk = 1'h0;
      forever #25 pclk = ~pclk;
   end
   // Verdict, also reached from a hung transfer
   task automatic tally_and_finish();
      if (failures == 0 && checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   // One APB transfer; request held until pready is seen high
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'h1;
      {pwrite, paddr, pwdata} <= {wr, a, d};
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1 && n < 16) begin
         @(posedge pclk);
         n++;
      end
      if (n == 16) begin
         failures++;
         tally_and_finish();
      end
      {rd, er} = {prdata, pslverr};
      {psel, penable} <= 2'h0;
   endtask
   // Read n ident bytes from base, compare with w; std byte 1 keeps 5 bits
   task automatic rd_bytes(input logic [7:0] base, input int n);
      for (int k = 0; k < n; k++) begin
         m = (n == 2 && k == 1) ? 32'hf8 : 32'hff;
         apb(1'h0, base + 8'(4 * k), 32'h0);
         chk(rd & m, {24'h0, w[31 - 8 * k -: 8]} & m);
      end
   endtask
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, bus_key} = '0;
      {pstrb, failures, checked} = {4'hf, 32'h0, 32'h0};
      repeat (6) @(posedge pclk);
      presetn <= 1'h1;
      // Window closed while unselected
      apb(1'h1, CID_TX_SEL_OFS, 32'h1);
      apb(1'h1, CID_TX_IDENT0_OFS, 32'ha5);
      apb(1'h1, CID_TX_SEL_OFS, 32'h0);
      apb(1'h1, CID_TX_IDENT0_OFS, 32'h5a);
      apb(1'h0, CID_TX_IDENT0_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'h1, CID_TX_SEL_OFS, 32'h1);
      apb(1'h0, CID_TX_IDENT0_OFS, 32'h0);
      chk(rd, 32'ha5);
      apb(1'h0, CID_RX_IDENT0_OFS, 32'h0);
      chk(rd, 32'h0);
      apb(1'h0, 8'h30, 32'h0);
      chk({31'h0, er}, 32'h1);
      // Extended then standard frame; SRR written as 1
      for (int f = 0; f < 2; f++) begin
         w = f ? {11'h5a3, 2'h2, 19'h0} : {ID[28:18], 2'h3, ID[17:0], 1'h1};
         key = f ? {11'h5a3, 18'h0} : ID;
         for (int k = 0; k < 4; k++)
            apb(1'h1, 8'(4 * k), {24'h0, w[31 - 8 * k -: 8]});
         rd_bytes(CID_TX_IDENT0_OFS, 4 - 2 * f);
         apb(1'h1, CID_TX_FLAG_OFS, 32'h1);
         bus_key <= key + 29'h1;
         @(posedge pclk);
         chk({31'h0, tx_outranks}, 32'h1);
         chk({3'h0, tx_key}, {3'h0, key});
         chk({31'h0, tx_pending}, 32'h1);
         bus_key <= key;
         @(posedge pclk);
         chk({31'h0, tx_outranks}, 32'h0);
         apb(1'h0, CID_TX_IDENT0_OFS, 32'h0);
         chk(rd, 32'h0);
         cid_can_node_inst.send(f ? 13 : 32, f, bits);
         chk(bits, f ? {19'h0, w[31:19]} : w);
         @(posedge pclk);
         chk({31'h0, tx_bit_valid}, 32'h0);
         cid_can_node_inst.end_frame();
         apb(1'h0, CID_TX_FLAG_OFS, 32'h0);
         chk(rd & 32'h7, 32'h7);
         chk({31'h0, tx_pending}, 32'h0);
      end
      // Received extended frame with SRR 0, then ignored write
      cid_can_node_inst.offer(ID, 1'h1, 1'h0, 1'h0);
      @(posedge pclk);
      chk({31'h0, rx_ready}, 32'h0);
      w = {ID[28:18], 2'h1, ID[17:0], 1'h0};
      rd_bytes(CID_RX_IDENT0_OFS, 4);
      apb(1'h1, CID_RX_IDENT0_OFS, 32'h0);
      rd_bytes(CID_RX_IDENT0_OFS, 1);
      apb(1'h1, CID_RX_FLAG_OFS, 32'h1);
      // Received standard remote frame
      cid_can_node_inst.offer({18'h0, 11'h2c7}, 1'h0, 1'h1, 1'h1);
      w = {11'h2c7, 2'h2, 19'h0};
      rd_bytes(CID_RX_IDENT0_OFS, 2);
      // Frame offered while full must leave the stored one alone
      cid_can_node_inst.offer(ID, 1'h1, 1'h1, 1'h1);
      rd_bytes(CID_RX_IDENT0_OFS, 2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
